// ### hdl/lci_indicators.sv
// Status lamps, scan sequencing and sync supervision of a light curtain
`timescale 1ns/1ps
// Behaviour
// - Emitter channel 1 normal: lamp one steady green, lamp two dark.
// - Emitter channel 2 normal: both emitter lamps steady green.
// - Reduced range: lamp one flashes green, lamp two dark on channel 1, flashing in step on 2.
// - External error: receiver lamp one flashes red slowly, else red or green by output state.
// - Internal error: receiver lamp one flashes red fast, distinct from the slow blink.
// - Yellow on when outputs off, interlock armed and locked, and the field is free.
// - Yellow on when outputs on and the controller gating request is asserted.
// - Yellow dark when the interlock is armed and released, or locked with the field interrupted.
// - Blue steady once blanking is taught, dark with no special function.
// - Blue short flashes on locked interrupted field, teaching, or restart needed; slow flashes on gating or override.
// - Sync with the emitter comes only from the two coded optical sync beams.
// - Beams are evaluated in repeated scans from first to last, setting the response time.
// - During gating both sync beams may be blocked up to 60 s before sync counts as lost.
module lci_indicators
  import lci_pkg::*;
#(
  parameter int unsigned P_SLOW_HALF = 32'(LCI_SLOW_HALF_CYC), // Slow blink half period
  parameter int unsigned P_FAST_HALF = 32'(LCI_FAST_HALF_CYC), // Fast blink half period
  parameter int unsigned P_SYNC_TOL  = 32'(LCI_SYNC_TOL_CYC),  // Sync blockage tolerance
  parameter int unsigned P_BEAM_CYC  = 32'(LCI_BEAM_CYC)       // Cycles per beam
) (
  input  wire logic         i_clk,               // System clock
  input  wire logic         i_rst_n,             // Async reset, low
  input  wire logic [7:0]   i_s_axi_awaddr,      // Write address
  input  wire logic         i_s_axi_awvalid,     // Write address valid
  output logic              o_s_axi_awready,     // Write address ready
  input  wire logic [31:0]  i_s_axi_wdata,       // Write data
  input  wire logic [3:0]   i_s_axi_wstrb,       // Write strobes
  input  wire logic         i_s_axi_wvalid,      // Write data valid
  output logic              o_s_axi_wready,      // Write data ready
  output logic [1:0]        o_s_axi_bresp,       // Write response
  output logic              o_s_axi_bvalid,      // Write response valid
  input  wire logic         i_s_axi_bready,      // Write response ready
  input  wire logic [7:0]   i_s_axi_araddr,      // Read address
  input  wire logic         i_s_axi_arvalid,     // Read address valid
  output logic              o_s_axi_arready,     // Read address ready
  output logic [31:0]       o_s_axi_rdata,       // Read data
  output logic [1:0]        o_s_axi_rresp,       // Read response
  output logic              o_s_axi_rvalid,      // Read data valid
  input  wire logic         i_s_axi_rready,      // Read data ready
  input  wire logic         i_safety_switching_output, // Safety outputs on
  input  wire logic         i_restart_interlock_armed, // Interlock armed
  input  wire logic         i_restart_interlock_locked, // Interlock locked
  input  wire logic         i_field_free,        // Protective field free
  input  wire logic         i_gate_request,      // Controller gating request
  input  wire logic         i_process_gating,    // Gating active
  input  wire logic         i_sync_beam_a,       // First sync beam received
  input  wire logic         i_sync_beam_b,       // Second sync beam received
  output lci_em_lamp_t      o_em_lamp,           // Emitter lamps
  output lci_rx_lamp_t      o_rx_lamp,           // Receiver lamps
  output logic [7:0]        o_scan_beam,         // Beam under evaluation
  output logic              o_scan_start,        // Pulse at first beam
  output logic              o_sync_lost          // Sync lost
);

  // Address decode shared by both channels
  function automatic lci_sel_t dec(input logic [7:0] a);
    case (a)
      LCI_OFF_CTRL: dec = LCI_SEL_CTRL;
      LCI_OFF_SCAN: dec = LCI_SEL_SCAN;
      LCI_OFF_STAT: dec = LCI_SEL_STAT;
      default:      dec = LCI_SEL_NONE;
    endcase
  endfunction

  // Byte strobes to bit mask
  function automatic logic [31:0] smask(input logic [3:0] s);
    smask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  logic [7:0]            pin_raw;
  logic [7:0]            sync1_reg;
  logic [7:0]            sync2_reg;
  logic [LCI_CTRL_W-1:0] ctrl_reg;
  logic [7:0]            scan_reg;
  logic [7:0]            awaddr_reg;
  logic [31:0]           wdata_reg;
  logic [3:0]            wstrb_reg;
  logic [31:0]           wm;
  logic [31:0]           stat;
  logic [31:0]           slow_cnt_reg;
  logic                  slow_ph_reg;
  logic [31:0]           fast_cnt_reg;
  logic                  fast_ph_reg;
  logic [31:0]           beam_tick_reg;
  logic [31:0]           blk_cnt_reg;
  logic                  short_fl;
  logic                  both_blk;
  lci_em_lamp_t          em_next;
  lci_rx_lamp_t          rx_next;

  // Synchronised pin levels
  logic safety_switching_output_on, ri_armed, ri_locked, fld_free, gate_req, gating, beam_a, beam_b;

  // Two-stage synchroniser for every pin input
  assign pin_raw = {i_sync_beam_b, i_sync_beam_a, i_process_gating, i_gate_request,
                    i_field_free, i_restart_interlock_locked, i_restart_interlock_armed,
                    i_safety_switching_output};

  generate
    for (genvar g = 0; g < 8; g++) begin : g_sync
      always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          sync1_reg[g] <= 1'b0;
          sync2_reg[g] <= 1'b0;
        end else begin
          sync1_reg[g] <= pin_raw[g];
          sync2_reg[g] <= sync1_reg[g];
        end
      end
    end
  endgenerate

  assign {beam_b, beam_a, gating, gate_req, fld_free, ri_locked, ri_armed, safety_switching_output_on} = sync2_reg;

  // Write channel: address and data taken in either order
  assign wm = smask(wstrb_reg);
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_s_axi_awready <= 1'b1;
      o_s_axi_wready  <= 1'b1;
      o_s_axi_bvalid  <= 1'b0;
      o_s_axi_bresp   <= LCI_RESP_OKAY;
      awaddr_reg      <= 8'h00;
      wdata_reg       <= 32'h0000_0000;
      wstrb_reg       <= 4'h0;
      ctrl_reg        <= LCI_CTRL_RST;
      scan_reg        <= LCI_SCAN_RST;
    end else begin
      if (i_s_axi_awvalid && o_s_axi_awready) begin
        awaddr_reg      <= i_s_axi_awaddr;
        o_s_axi_awready <= 1'b0;
      end
      if (i_s_axi_wvalid && o_s_axi_wready) begin
        wdata_reg      <= i_s_axi_wdata;
        wstrb_reg      <= i_s_axi_wstrb;
        o_s_axi_wready <= 1'b0;
      end
      if (!o_s_axi_awready && !o_s_axi_wready && !o_s_axi_bvalid) begin
        o_s_axi_bvalid <= 1'b1;
        o_s_axi_bresp  <= LCI_RESP_OKAY;
        unique case (dec(awaddr_reg))
          LCI_SEL_CTRL: begin
            ctrl_reg <= (ctrl_reg & ~wm[LCI_CTRL_W-1:0]) | (wdata_reg[LCI_CTRL_W-1:0]
                        & wm[LCI_CTRL_W-1:0]);
          end
          LCI_SEL_SCAN: begin
            scan_reg <= (scan_reg & ~wm[7:0]) | (wdata_reg[7:0] & wm[7:0]);
          end
          LCI_SEL_STAT: begin
            ctrl_reg <= ctrl_reg; // Read-only, write ignored
          end
          LCI_SEL_NONE: begin
            o_s_axi_bresp <= LCI_RESP_SLVERR;
          end
        endcase
      end
      if (o_s_axi_bvalid && i_s_axi_bready) begin
        o_s_axi_bvalid  <= 1'b0;
        o_s_axi_awready <= 1'b1;
        o_s_axi_wready  <= 1'b1;
      end
    end
  end

  // Status word
  always_comb begin
    stat                             = 32'h0000_0000;
    stat[LCI_SB_LOST]                = o_sync_lost;
    stat[LCI_SB_BLK]                 = both_blk;
    stat[LCI_SF_BEAM +: 8]           = o_scan_beam;
    stat[LCI_SF_RX +: 4]             = o_rx_lamp;
    stat[LCI_SF_EM +: 3]             = o_em_lamp;
  end

  // Read channel
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_s_axi_arready <= 1'b1;
      o_s_axi_rvalid  <= 1'b0;
      o_s_axi_rdata   <= 32'h0000_0000;
      o_s_axi_rresp   <= LCI_RESP_OKAY;
    end else if (i_s_axi_arvalid && o_s_axi_arready) begin
      o_s_axi_arready <= 1'b0;
      o_s_axi_rvalid  <= 1'b1;
      o_s_axi_rresp   <= LCI_RESP_OKAY;
      unique case (dec(i_s_axi_araddr))
        LCI_SEL_CTRL: o_s_axi_rdata <= {{(32-LCI_CTRL_W){1'b0}}, ctrl_reg};
        LCI_SEL_SCAN: o_s_axi_rdata <= {24'h00_0000, scan_reg};
        LCI_SEL_STAT: o_s_axi_rdata <= stat;
        LCI_SEL_NONE: begin
          o_s_axi_rdata <= 32'h0000_0000;
          o_s_axi_rresp <= LCI_RESP_SLVERR;
        end
      endcase
    end else if (o_s_axi_rvalid && i_s_axi_rready) begin
      o_s_axi_rvalid  <= 1'b0;
      o_s_axi_arready <= 1'b1;
    end
  end

  // Slow blink phase, about 1 Hz
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      slow_cnt_reg <= 32'h0000_0000;
      slow_ph_reg  <= 1'b0;
    end else if (slow_cnt_reg >= P_SLOW_HALF - 32'd1) begin
      slow_cnt_reg <= 32'h0000_0000;
      slow_ph_reg  <= ~slow_ph_reg;
    end else begin
      slow_cnt_reg <= slow_cnt_reg + 32'd1;
    end
  end

  // Fast blink phase, about 10 Hz
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fast_cnt_reg <= 32'h0000_0000;
      fast_ph_reg  <= 1'b0;
    end else if (fast_cnt_reg >= P_FAST_HALF - 32'd1) begin
      fast_cnt_reg <= 32'h0000_0000;
      fast_ph_reg  <= ~fast_ph_reg;
    end else begin
      fast_cnt_reg <= fast_cnt_reg + 32'd1;
    end
  end

  // Short flash: one fast half period at the start of each slow on phase
  assign short_fl = slow_ph_reg && (slow_cnt_reg < P_FAST_HALF);

  // Lamp decisions
  always_comb begin
    em_next = '0;
    rx_next = '0;
    if (ctrl_reg[LCI_CB_EMERR]) begin
      em_next.one_red = 1'b1;
    end else if (ctrl_reg[LCI_CB_RANGE]) begin
      em_next.one_green = slow_ph_reg;
      em_next.two_green = slow_ph_reg && ctrl_reg[LCI_CB_CH2];
    end else begin
      em_next.one_green = 1'b1;
      em_next.two_green = ctrl_reg[LCI_CB_CH2];
    end
    if (ctrl_reg[LCI_CB_INTERR]) begin
      rx_next.one_red = fast_ph_reg;
    end else if (ctrl_reg[LCI_CB_EXTERR]) begin
      rx_next.one_red = slow_ph_reg;
    end else begin
      rx_next.one_red   = ~safety_switching_output_on;
      rx_next.one_green = safety_switching_output_on;
    end
    // Yellow dark in every other interlock case
    rx_next.two_yellow = (!safety_switching_output_on && ri_armed && ri_locked && fld_free)
                         || (safety_switching_output_on && gate_req);
    if ((!fld_free && ri_locked) || ctrl_reg[LCI_CB_TEACH] || ctrl_reg[LCI_CB_RESTART]) begin
      rx_next.three_blue = short_fl;
    end else if (gating || ctrl_reg[LCI_CB_OVERRIDE]) begin
      rx_next.three_blue = slow_ph_reg;
    end else begin
      rx_next.three_blue = ctrl_reg[LCI_CB_TAUGHT];
    end
  end

  // Lamp outputs
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_em_lamp <= '0;
      o_rx_lamp <= '0;
    end else begin
      o_em_lamp <= em_next;
      o_rx_lamp <= rx_next;
    end
  end

  // Scan sequencer over the configured beam count
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      beam_tick_reg <= 32'h0000_0000;
      o_scan_beam   <= 8'h00;
      o_scan_start  <= 1'b0;
    end else begin
      o_scan_start <= 1'b0;
      if (beam_tick_reg >= P_BEAM_CYC - 32'd1) begin
        beam_tick_reg <= 32'h0000_0000;
        if ((scan_reg == 8'h00) || (o_scan_beam >= scan_reg - 8'h01)) begin
          o_scan_beam  <= 8'h00;
          o_scan_start <= 1'b1;
        end else begin
          o_scan_beam <= o_scan_beam + 8'h01;
        end
      end else begin
        beam_tick_reg <= beam_tick_reg + 32'd1;
      end
    end
  end

  // Sync supervision from the optical sync beams only
  assign both_blk = !beam_a && !beam_b;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      blk_cnt_reg <= 32'h0000_0000;
      o_sync_lost <= 1'b0;
    end else begin
      if (!both_blk) begin
        blk_cnt_reg <= 32'h0000_0000;
      end else if (blk_cnt_reg < P_SYNC_TOL) begin
        blk_cnt_reg <= blk_cnt_reg + 32'd1;
      end
      o_sync_lost <= both_blk && (!gating || blk_cnt_reg >= P_SYNC_TOL);
    end
  end

endmodule

// ### include/lci_pkg.sv
// Constants and types for the light curtain status indicator block
package lci_pkg;
  // Clock and timing figures
  localparam longint unsigned LCI_CLK_HZ       = 40_000_000;
  localparam longint unsigned LCI_CLK_NS       = 25;
  localparam longint unsigned LCI_SLOW_HALF_MS = 500;
  localparam longint unsigned LCI_FAST_HALF_MS = 50;
  localparam longint unsigned LCI_SYNC_TOL_S   = 60;
  localparam longint unsigned LCI_BEAM_NS      = 1000;
  localparam longint unsigned LCI_SLOW_HALF_CYC = LCI_CLK_HZ / 1000 * LCI_SLOW_HALF_MS;
  localparam longint unsigned LCI_FAST_HALF_CYC = LCI_CLK_HZ / 1000 * LCI_FAST_HALF_MS;
  localparam longint unsigned LCI_SYNC_TOL_CYC  = LCI_CLK_HZ * LCI_SYNC_TOL_S;
  localparam longint unsigned LCI_BEAM_CYC      = LCI_BEAM_NS / LCI_CLK_NS;

  // Register offsets
  localparam logic [7:0] LCI_OFF_CTRL = 8'h00;
  localparam logic [7:0] LCI_OFF_SCAN = 8'h04;
  localparam logic [7:0] LCI_OFF_STAT = 8'h08;

  // Control register field positions
  localparam int LCI_CB_CH2      = 0;
  localparam int LCI_CB_RANGE    = 1;
  localparam int LCI_CB_EMERR    = 2;
  localparam int LCI_CB_EXTERR   = 3;
  localparam int LCI_CB_INTERR   = 4;
  localparam int LCI_CB_TAUGHT   = 5;
  localparam int LCI_CB_TEACH    = 6;
  localparam int LCI_CB_RESTART  = 7;
  localparam int LCI_CB_OVERRIDE = 8;
  localparam int LCI_CTRL_W      = 9;

  // Status register field positions
  localparam int LCI_SB_LOST = 0;
  localparam int LCI_SB_BLK  = 1;
  localparam int LCI_SF_BEAM = 8;
  localparam int LCI_SF_RX   = 16;
  localparam int LCI_SF_EM   = 20;

  // Reset values
  localparam logic [8:0] LCI_CTRL_RST = 9'h000;
  localparam logic [7:0] LCI_SCAN_RST = 8'h10;

  // Bus responses
  localparam logic [1:0] LCI_RESP_OKAY   = 2'h0;
  localparam logic [1:0] LCI_RESP_SLVERR = 2'h2;

  // Address decode result
  typedef enum logic [1:0] {
    LCI_SEL_CTRL = 2'b00,
    LCI_SEL_SCAN = 2'b01,
    LCI_SEL_STAT = 2'b10,
    LCI_SEL_NONE = 2'b11
  } lci_sel_t;

  // Emitter lamp drive
  typedef struct packed {
    logic one_green;
    logic one_red;
    logic two_green;
  } lci_em_lamp_t;

  // Receiver lamp drive
  typedef struct packed {
    logic one_green;
    logic one_red;
    logic two_yellow;
    logic three_blue;
  } lci_rx_lamp_t;
endpackage

// ### verif/lci_indicators_asserts.sv
// Checker for lamp, scan and sync outputs of the status indicator block
`timescale 1ns/1ps
module lci_indicators_asserts
  import lci_pkg::*;
#(
  parameter int unsigned P_SYNC_TOL = 50 // Sync blockage tolerance
) (
  input wire logic         i_clk,                      // Clock
  input wire logic         i_rst_n,                    // Reset, low
  input wire logic         i_safety_switching_output,  // Outputs on
  input wire logic         i_restart_interlock_armed,  // Interlock armed
  input wire logic         i_restart_interlock_locked, // Interlock locked
  input wire logic         i_field_free,               // Field free
  input wire logic         i_gate_request,             // Gating request
  input wire logic         i_process_gating,           // Gating active
  input wire logic         i_sync_beam_a,              // Sync beam a
  input wire logic         i_sync_beam_b,              // Sync beam b
  input wire lci_em_lamp_t o_em_lamp,                  // Emitter lamps
  input wire lci_rx_lamp_t o_rx_lamp,                  // Receiver lamps
  input wire logic [7:0]   o_scan_beam,                // Beam index
  input wire logic         o_scan_start,               // Scan start pulse
  input wire logic         o_sync_lost                 // Sync lost
);
  logic        blk;
  logic        yel;
  int unsigned cnt_reg;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // Pin level views of sync blockage and of the yellow lamp condition
  assign blk = !i_sync_beam_a && !i_sync_beam_b;
  assign yel = (!i_safety_switching_output && i_restart_interlock_armed
             && i_restart_interlock_locked && i_field_free)
             || (i_safety_switching_output && i_gate_request);
  // Counts consecutive blocked cycles during gating
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) cnt_reg <= 0;
    else if (blk && i_process_gating) cnt_reg <= cnt_reg + 1;
    else cnt_reg <= 0;
  end
  a_yellow_on: assert property (yel [*4] |-> o_rx_lamp.two_yellow)
    else $error("yellow lamp dark while its condition held");
  a_yellow_off: assert property (!yel [*4] |-> !o_rx_lamp.two_yellow)
    else $error("yellow lamp lit without its condition");
  a_green_cause: assert property (o_rx_lamp.one_green |-> $past(i_safety_switching_output, 3))
    else $error("receiver lamp green while outputs off");
  a_emitter_pair: assert property (o_em_lamp.two_green |-> o_em_lamp.one_green && !o_em_lamp.one_red)
    else $error("emitter lamp two green without lamp one green");
  a_sync_lost_out: assert property ((blk && !i_process_gating) [*4] |-> o_sync_lost)
    else $error("sync not lost with both beams blocked outside gating");
  a_sync_back: assert property (!blk [*4] |-> !o_sync_lost)
    else $error("sync lost while a sync beam is received");
  a_gate_keep: assert property (cnt_reg > 3 && cnt_reg < P_SYNC_TOL - 2 && !o_sync_lost
    |=> !o_sync_lost)
    else $error("sync lost before gating tolerance ran out");
  a_gate_lost: assert property (cnt_reg == P_SYNC_TOL + 6 |-> o_sync_lost)
    else $error("sync kept after gating tolerance ran out");
  a_scan_wrap: assert property (o_scan_start |-> o_scan_beam == 8'h00)
    else $error("scan start pulse away from the first beam");
  a_scan_step: assert property ($changed(o_scan_beam) && o_scan_beam != 8'h00
    |-> o_scan_beam == $past(o_scan_beam) + 8'h01)
    else $error("beam index skipped a beam");
endmodule
bind lci_indicators lci_indicators_asserts #(.P_SYNC_TOL(P_SYNC_TOL)) u_lci_chk (.*);

// ### verif/testbench.sv
// Self-checking bench for the light curtain status indicator block
`timescale 1ns/1ps
module testbench
  import lci_pkg::*;
;
  logic         i_clk, i_rst_n, i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready;
  logic         i_s_axi_arvalid, i_s_axi_rready, i_safety_switching_output;
  logic         i_restart_interlock_armed, i_restart_interlock_locked, i_field_free;
  logic         i_gate_request, i_process_gating, i_sync_beam_a, i_sync_beam_b;
  logic         o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready;
  logic         o_s_axi_rvalid, o_scan_start, o_sync_lost, men, mdone, smp, prv;
  logic [7:0]   i_s_axi_awaddr, i_s_axi_araddr, o_scan_beam, sel;
  logic [31:0]  i_s_axi_wdata, o_s_axi_rdata, d;
  logic [3:0]   i_s_axi_wstrb;
  logic [1:0]   o_s_axi_bresp, o_s_axi_rresp;
  lci_em_lamp_t o_em_lamp;
  lci_rx_lamp_t o_rx_lamp;
  logic [8:0]   vec;
  logic [33:0]  exq[$];
  int           fail_count, checks_done, cyc, rises, highs;
  // Rows: address, value, pins, watched output, expected rises and high cycles
  localparam logic [55:0] TBL [16] = '{
    56'h00_0002_13_02_0450, 56'h00_0002_13_00_0000, 56'h00_0003_13_00_0450,
    56'h00_0004_13_01_00A0, 56'h00_0008_13_05_0450, 56'h00_0010_13_05_1450,
    56'h00_0020_13_03_00A0, 56'h00_0040_13_03_0410, 56'h00_0080_13_03_0410,
    56'h00_0100_13_03_0450, 56'h00_0000_23_03_0410, 56'h00_0000_14_07_0173,
    56'h00_0000_14_03_0450, 56'h00_0000_10_07_00A0, 56'h04_0005_13_08_1010,
    56'h04_0001_13_08_5050};
  assign vec = {o_scan_start, o_sync_lost, o_rx_lamp, o_em_lamp};
  // Block under test with shortened counts
  lci_indicators #(.P_SLOW_HALF(20), .P_FAST_HALF(4), .P_SYNC_TOL(50), .P_BEAM_CYC(2))
    lci_indicators_inst (.*);
  initial i_clk = 1'b0;
  always #12.5 i_clk = ~i_clk;
  // Prints the counts and the verdict, then stops
  task automatic conclude;
    $display("Checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Compares one observed result with the oldest expectation
  task automatic chk(input logic [33:0] got);
    logic [33:0] e;
    e = (exq.size() > 0) ? exq.pop_front() : 34'h3FFFFFFFF;
    checks_done++;
    if (got !== e) begin
      fail_count++;
      $display("Error at %0t: expected %h got %h", $time, e, got);
    end
  endtask
  // Watches results half a cycle after each edge, once they have settled
  always @(negedge i_clk) begin
    if (o_s_axi_rvalid && i_s_axi_rready) chk({o_s_axi_rresp, o_s_axi_rdata});
    if (o_s_axi_bvalid && i_s_axi_bready) chk({o_s_axi_bresp, 32'h0});
    if (smp) chk({27'h0, vec[7:4], vec[2:0]});
    if (men) begin
      rises += int'(vec[sel] && !prv);
      highs += int'(vec[sel]);
    end
    if (mdone) begin
      chk({18'h0, 8'(rises), 8'(highs)});
      rises = 0;
      highs = 0;
    end
    prv = vec[sel];
  end
  // Hang guard, well above the length of all tests
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 8000) begin
      fail_count++;
      conclude();
    end
  end
  // Register write; each channel is released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s,
                    input logic [1:0] r);
    logic ak, wk, bk;
    exq.push_back({r, 32'h0});
    @(posedge i_clk);
    {i_s_axi_awaddr, i_s_axi_wdata, i_s_axi_wstrb} <= {a, v, s};
    {i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready} <= 3'b111;
    bk = 1'b0;
    while (!bk) begin
      @(negedge i_clk);
      ak = o_s_axi_awready;
      wk = o_s_axi_wready;
      bk = o_s_axi_bvalid;
      @(posedge i_clk);
      if (ak) i_s_axi_awvalid <= 1'b0;
      if (wk) i_s_axi_wvalid <= 1'b0;
    end
    i_s_axi_bready <= 1'b0;
  endtask
  // Register read, answer compared by the watcher
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    logic ak, rk;
    exq.push_back(e);
    @(posedge i_clk);
    {i_s_axi_araddr, i_s_axi_arvalid, i_s_axi_rready} <= {a, 2'b11};
    rk = 1'b0;
    while (!rk) begin
      @(negedge i_clk);
      ak = o_s_axi_arready;
      rk = o_s_axi_rvalid;
      @(posedge i_clk);
      if (ak) i_s_axi_arvalid <= 1'b0;
    end
    i_s_axi_rready <= 1'b0;
  endtask
  // Drives the status pins: outputs, armed, locked, free, request, gating, beams
  task automatic pins(input logic [7:0] p);
    @(posedge i_clk);
    {i_safety_switching_output, i_restart_interlock_armed, i_restart_interlock_locked,
     i_field_free, i_gate_request, i_process_gating, i_sync_beam_a, i_sync_beam_b} <= p;
  endtask
  // Samples the lamps once the three edge latency has passed
  task automatic look(input logic [6:0] e);
    exq.push_back({27'h0, e});
    repeat (4) @(posedge i_clk);
    smp <= 1'b1;
    @(posedge i_clk);
    smp <= 1'b0;
  endtask
  // Counts rising edges and high cycles of one output over 160 cycles
  task automatic meas(input logic [7:0] s, input logic [15:0] e);
    exq.push_back({18'h0, e});
    sel <= s;
    repeat (8) @(posedge i_clk);
    men <= 1'b1;
    repeat (160) @(posedge i_clk);
    men <= 1'b0;
    mdone <= 1'b1;
    @(posedge i_clk);
    mdone <= 1'b0;
  endtask
  // Main sequence
  initial begin
    logic [7:0] p;
    logic       c;
    logic       y;
    {i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready, i_s_axi_arvalid} = '0;
    {i_s_axi_rready, men, mdone, smp, i_rst_n, sel} = '0;
    {i_s_axi_awaddr, i_s_axi_araddr, i_s_axi_wdata, i_s_axi_wstrb} = '0;
    {i_safety_switching_output, i_restart_interlock_armed, i_restart_interlock_locked,
     i_field_free, i_gate_request, i_process_gating, i_sync_beam_a, i_sync_beam_b} = 8'h13;
    void'($urandom(32'hFACD));
    repeat (5) @(posedge i_clk);
    i_rst_n <= 1'b1;
    rd(LCI_OFF_CTRL, {LCI_RESP_OKAY, 23'h0, LCI_CTRL_RST});
    rd(LCI_OFF_SCAN, {LCI_RESP_OKAY, 24'h0, LCI_SCAN_RST});
    d = $urandom;
    wr(LCI_OFF_CTRL, d, 4'hF, LCI_RESP_OKAY);
    rd(LCI_OFF_CTRL, {LCI_RESP_OKAY, 23'h0, d[8:0]});
    wr(LCI_OFF_CTRL, 32'h0, 4'h1, LCI_RESP_OKAY);
    rd(LCI_OFF_CTRL, {LCI_RESP_OKAY, 23'h0, d[8], 8'h00});
    wr(LCI_OFF_STAT, 32'hFFFFFFFF, 4'hF, LCI_RESP_OKAY);
    wr(8'h0C, 32'hFFFFFFFF, 4'hF, LCI_RESP_SLVERR);
    rd(8'h0C, {LCI_RESP_SLVERR, 32'h0});
    $display("Test registers done");
    for (int n = 0; n < 12; n++) begin
      c = 1'($urandom);
      p = (8'($urandom) & 8'hF8) | 8'h03;
      if (n < 2) p = n ? 8'h8B : 8'h73;
      y = (!p[7] && p[6] && p[5] && p[4]) || (p[7] && p[3]);
      wr(LCI_OFF_CTRL, {31'h0, c}, 4'hF, LCI_RESP_OKAY);
      pins(p);
      look({1'b0, p[7], !p[7], y, 1'b1, 1'b0, c});
    end
    $display("Test steady lamps done");
    foreach (TBL[k]) begin
      wr(TBL[k][55:48], {16'h0, TBL[k][47:32]}, 4'hF, LCI_RESP_OKAY);
      pins(TBL[k][31:24]);
      meas(TBL[k][23:16], TBL[k][15:0]);
    end
    rd(LCI_OFF_STAT, {LCI_RESP_OKAY, (32'h4 << LCI_SF_EM) | (32'h4 << LCI_SF_RX)});
    $display("Test blink patterns done");
    conclude();
  end
endmodule
